/* core/cimf_pkg.sv */
// Purpose: shared constants and carriers for the indexed mixer and format register bank
// Assumes: byte-wide host port, two direct ports (index and indexed data)
// Notes:   offsets are register indexes on the indexed data port
package cimf_pkg;

  // ************************************************************
  // direct port selects
  // ************************************************************
  localparam logic [1:0] CIMF_PORT_INDEX = 2'h0;
  localparam logic [1:0] CIMF_PORT_DATA  = 2'h1;

  // ************************************************************
  // indexed register offsets
  // ************************************************************
  localparam logic [3:0] CIMF_IX_LEFT_INPUT   = 4'h0;
  localparam logic [3:0] CIMF_IX_RIGHT_INPUT  = 4'h1;
  localparam logic [3:0] CIMF_IX_LEFT_AUX1    = 4'h2;
  localparam logic [3:0] CIMF_IX_RIGHT_AUX1   = 4'h3;
  localparam logic [3:0] CIMF_IX_LEFT_AUX2    = 4'h4;
  localparam logic [3:0] CIMF_IX_RIGHT_AUX2   = 4'h5;
  localparam logic [3:0] CIMF_IX_LEFT_OUTPUT  = 4'h6;
  localparam logic [3:0] CIMF_IX_RIGHT_OUTPUT = 4'h7;
  localparam logic [3:0] CIMF_IX_FORMAT       = 4'h8;

  // ************************************************************
  // reset values and held-bit masks
  // ************************************************************
  localparam logic [7:0] CIMF_RST_INPUT  = 8'h00;
  localparam logic [7:0] CIMF_RST_AUX    = 8'h80;
  localparam logic [7:0] CIMF_RST_OUTPUT = 8'h80;
  localparam logic [7:0] CIMF_RST_FORMAT = 8'h00;
  localparam logic [7:0] CIMF_INIT_READ  = 8'h80;
  localparam logic [7:0] CIMF_MASK_INPUT  = 8'hEF;
  localparam logic [7:0] CIMF_MASK_AUX    = 8'h9F;
  localparam logic [7:0] CIMF_MASK_OUTPUT = 8'hBF;
  localparam logic [7:0] CIMF_MASK_FORMAT = 8'h7F;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CIMF_BIT_SRC_LO   = 6;
  localparam int CIMF_BIT_BOOST    = 5;
  localparam int CIMF_BIT_MUTE     = 7;
  localparam int CIMF_BIT_XTAL     = 0;
  localparam int CIMF_BIT_DIV_LO   = 1;
  localparam int CIMF_BIT_STEREO   = 4;
  localparam int CIMF_BIT_COMPAND  = 5;
  localparam int CIMF_BIT_FMT      = 6;
  localparam int CIMF_BIT_UNLOCK   = 6;

  // ************************************************************
  // gain steps in tenths of a dB, and divide factors
  // ************************************************************
  localparam int CIMF_IN_STEP_DB10  = 15;
  localparam int CIMF_BOOST_DB10    = 200;
  localparam int CIMF_AUX_ZERO_CODE = 8;
  localparam int CIMF_DIV_W         = 12;
  localparam logic [11:0] CIMF_DIV_TABLE [8] = '{12'd3072, 12'd1536, 12'd896, 12'd768,
                                                 12'd448, 12'd384, 12'd512, 12'd2560};

  // ************************************************************
  // enumerations and carriers
  // ************************************************************
  typedef enum logic [1:0] {CIMF_SRC_LINE, CIMF_SRC_AUX1, CIMF_SRC_MIC, CIMF_SRC_MIX}
    cimf_src_e;
  typedef enum logic [1:0] {CIMF_FMT_U8, CIMF_FMT_S16, CIMF_FMT_ULAW, CIMF_FMT_ALAW}
    cimf_fmt_e;

  typedef struct packed {
    cimf_src_e        src;
    logic             boost_on;
    logic [3:0]       gain;
    logic signed [9:0] gain_db10;
  } cimf_input_s;

  typedef struct packed {
    logic             mute;
    logic [4:0]       atten;
    logic signed [9:0] gain_db10;
  } cimf_aux_s;

  typedef struct packed {
    logic             mute;
    logic [5:0]       atten;
    logic signed [10:0] gain_db10;
  } cimf_out_s;

  typedef struct packed {
    logic             crystal_b;
    logic [2:0]       divide_sel;
    logic [11:0]      divide_factor;
    logic             stereo;
    cimf_fmt_e        fmt;
    logic             unsupported;
  } cimf_format_s;

endpackage : cimf_pkg

/* core/cimf_regs.sv */
// Purpose: indexed registers 0 to 8 of the codec, mixer levels and sample format
// Assumes: host strobes are synchronous one-cycle pulses on core_clk
// Notes:   decoded fields drive the analog and rate logic of the device
`timescale 1ns/1ps

// Notes on behaviour
// R1 - host writes index on port 0, then reads or writes port 1
// R2 - input gain steps +1.5 dB per code, 0 to +22.5 dB
// R3 - mic boost bit adds +20 dB to that channel's mic input
// R4 - source field picks line, aux one, mic or post-mix output
// R5 - aux attenuation steps -1.5 dB, code 8 is 0 dB, code 0 is +12 dB
// R6 - aux mute bit silences that aux channel; resets set, 80h
// R7 - output attenuation steps 1.5 dB, 0 dB to -94.5 dB
// R8 - output mute bit silences that output; resets set
// R9 - host writes zero in reserved bits
// R10 - format register writes ignored unless mode change unlock is set
// R11 - crystal select picks crystal a or crystal b as rate clock
// R12 - divide field chooses one of eight factors; 4 and 5 unsupported on crystal a
// R13 - any clock on a crystal input is divided by the selected factor
// R14 - stereo alternates left and right; mono plays both, captures left
// R15 - companding bit and format bit pick one of four sample formats
// R16 - input registers reset to zero, format register to zero
// R17 - unlock bit mutes both outputs while set
// R18 - while initialising, data port ignores writes and reads 80h
// R19 - data port reads the selected register, unheld bits as zero
module cimf_regs
  import cimf_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // host byte port
  input  wire logic [1:0]   direct_port_select,
  input  wire logic         host_wr,
  input  wire logic         host_rd,
  input  wire logic [7:0]   host_wdata,
  output logic [7:0]        host_rdata,
  // device state
  input  wire logic         init_busy,
  output logic              mode_change_unlock,
  output logic [3:0]        indirect_index_field,
  // decoded controls
  output cimf_input_s       left_input,
  output cimf_input_s       right_input,
  output cimf_aux_s         left_aux_one,
  output cimf_aux_s         right_aux_one,
  output cimf_aux_s         left_aux_two,
  output cimf_aux_s         right_aux_two,
  output cimf_out_s         left_output,
  output cimf_out_s         right_output,
  output cimf_format_s      rate_format,
  // sample rate clocking
  input  wire logic         crystal_a_input,
  input  wire logic         crystal_b_input,
  output logic              sample_tick
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    // host side: stored index, unlock and the nine indexed bytes
    logic [3:0] index;
    logic       unlock;
    logic [7:0] in_l;
    logic [7:0] in_r;
    logic [7:0] aux1_l;
    logic [7:0] aux1_r;
    logic [7:0] aux2_l;
    logic [7:0] aux2_r;
    logic [7:0] out_l;
    logic [7:0] out_r;
    logic [7:0] fmt;
    // last read byte, held until the next read strobe
    logic [7:0] rdata;
    // crystal sync stages and the level each stage pair last agreed on
    logic [2:0] xa_sync;
    logic [2:0] xb_sync;
    logic       xa_acc;
    logic       xb_acc;
    logic [11:0] div_cnt;
    logic       tick;
  } cimf_state_s;

  cimf_state_s st_ff;
  cimf_state_s nxt_st;

  // ************************************************************
  // decode helpers
  // ************************************************************
  // input gain in tenths of a dB, boost only counts when mic is the source
  function automatic logic signed [9:0] cimf_in_gain(input logic [7:0] r);
    logic signed [9:0] g;
    g = 10'(r[3:0] * CIMF_IN_STEP_DB10);                      // [R2]
    if (r[CIMF_BIT_BOOST] && r[7:6] == 2'(CIMF_SRC_MIC))
      g = 10'(g + CIMF_BOOST_DB10);                           // [R3]
    return g;
  endfunction : cimf_in_gain

  // input control: source, boost and gain code, all per channel
  function automatic cimf_input_s cimf_dec_in(input logic [7:0] r);
    cimf_input_s d;
    d.src       = cimf_src_e'(r[7:6]);                        // [R4]
    d.boost_on  = r[CIMF_BIT_BOOST];
    d.gain      = r[3:0];
    d.gain_db10 = cimf_in_gain(r);
    return d;
  endfunction : cimf_dec_in

  // aux: code 8 is unity, each code 1.5 dB quieter
  function automatic cimf_aux_s cimf_dec_aux(input logic [7:0] r);
    cimf_aux_s d;
    d.mute      = r[CIMF_BIT_MUTE];                           // [R6]
    d.atten     = r[4:0];
    d.gain_db10 = 10'(CIMF_IN_STEP_DB10 * (CIMF_AUX_ZERO_CODE - int'(r[4:0]))); // [R5]
    return d;
  endfunction : cimf_dec_aux

  // output: unlock forces mute so a rate change never reaches the speakers
  function automatic cimf_out_s cimf_dec_out(input logic [7:0] r, input logic unlock);
    cimf_out_s d;
    d.mute      = r[CIMF_BIT_MUTE] | unlock;                  // [R8] [R17]
    d.atten     = r[5:0];
    d.gain_db10 = 11'(-(CIMF_IN_STEP_DB10 * int'(r[5:0])));   // [R7]
    return d;
  endfunction : cimf_dec_out

  // register contents as seen on the data port
  function automatic logic [7:0] cimf_read_sel(input cimf_state_s s);
    logic [7:0] v;
    // indexes 9 to 15 are not held in this block and read as zero
    unique case (s.index)                                     // [R19]
      CIMF_IX_LEFT_INPUT:   v = s.in_l;
      CIMF_IX_RIGHT_INPUT:  v = s.in_r;
      CIMF_IX_LEFT_AUX1:    v = s.aux1_l;
      CIMF_IX_RIGHT_AUX1:   v = s.aux1_r;
      CIMF_IX_LEFT_AUX2:    v = s.aux2_l;
      CIMF_IX_RIGHT_AUX2:   v = s.aux2_r;
      CIMF_IX_LEFT_OUTPUT:  v = s.out_l;
      CIMF_IX_RIGHT_OUTPUT: v = s.out_r;
      CIMF_IX_FORMAT:       v = s.fmt;
      default:              v = 8'h00;
    endcase
    return v;
  endfunction : cimf_read_sel

  // accepted crystal level: moves only once stages two and three agree, so a
  // level caught mid-transition in stage one is never acted on
  function automatic logic cimf_sync_level(input logic [2:0] s, input logic acc);
    return (s[1] == s[2]) ? s[2] : acc;
  endfunction : cimf_sync_level

  // ************************************************************
  // next state
  // ************************************************************
  logic       wr_idx;
  logic       wr_data;
  logic [7:0] wmask;
  logic [7:0] wv;
  logic       xa_lvl;
  logic       xb_lvl;
  logic       xa_rise;
  logic       xb_rise;
  logic       rate_edge;
  logic [11:0] div_lim;

  always_comb
  begin
    nxt_st  = st_ff;
    // index writes stay open while initialising; only data writes are held off
    wr_idx  = host_wr && direct_port_select == CIMF_PORT_INDEX;
    // initialising blocks data writes so half-set state cannot leak out
    wr_data = host_wr && direct_port_select == CIMF_PORT_DATA && !init_busy;  // [R18]
    wmask   = 8'h00;
    wv      = host_wdata;
    // index port: low nibble picks the register, bit 6 is unlock
    if (wr_idx)
    begin
      nxt_st.index  = host_wdata[3:0];                        // [R1]
      nxt_st.unlock = host_wdata[CIMF_BIT_UNLOCK];
    end
    // data port write into the selected register, unheld bits dropped
    if (wr_data)
    begin
      // mask of held bits for the selected register
      unique case (st_ff.index)
        CIMF_IX_LEFT_INPUT, CIMF_IX_RIGHT_INPUT: wmask = CIMF_MASK_INPUT;
        CIMF_IX_LEFT_AUX1, CIMF_IX_RIGHT_AUX1,
        CIMF_IX_LEFT_AUX2, CIMF_IX_RIGHT_AUX2:   wmask = CIMF_MASK_AUX;
        CIMF_IX_LEFT_OUTPUT, CIMF_IX_RIGHT_OUTPUT: wmask = CIMF_MASK_OUTPUT;
        CIMF_IX_FORMAT:  wmask = st_ff.unlock ? CIMF_MASK_FORMAT : 8'h00;  // [R10]
        default:         wmask = 8'h00;
      endcase
      // reserved bits are zero by host contract; masking keeps them zero anyway
      wv = host_wdata & wmask;                                // [R9]
      unique case (st_ff.index)                               // [R1]
        CIMF_IX_LEFT_INPUT:   nxt_st.in_l   = wv;
        CIMF_IX_RIGHT_INPUT:  nxt_st.in_r   = wv;
        CIMF_IX_LEFT_AUX1:    nxt_st.aux1_l = wv;
        CIMF_IX_RIGHT_AUX1:   nxt_st.aux1_r = wv;
        CIMF_IX_LEFT_AUX2:    nxt_st.aux2_l = wv;
        CIMF_IX_RIGHT_AUX2:   nxt_st.aux2_r = wv;
        CIMF_IX_LEFT_OUTPUT:  nxt_st.out_l  = wv;
        CIMF_IX_RIGHT_OUTPUT: nxt_st.out_r  = wv;
        CIMF_IX_FORMAT:       if (st_ff.unlock) nxt_st.fmt = wv;  // [R10]
        default:              ;
      endcase
    end
    // read data captured on the strobe, held until the next read
    // ports 2 and 3 belong to other blocks and read as zero here, or 80h while initialising
    if (host_rd)
    begin
      if (init_busy)
        nxt_st.rdata = CIMF_INIT_READ;                        // [R18]
      else if (direct_port_select == CIMF_PORT_INDEX)
        nxt_st.rdata = {1'b0, st_ff.unlock, 2'b00, st_ff.index};
      else if (direct_port_select == CIMF_PORT_DATA)
        nxt_st.rdata = cimf_read_sel(st_ff);                  // [R19]
      else
        nxt_st.rdata = 8'h00;
    end
    // crystal inputs: three stages, an edge counts once stages two and three agree
    nxt_st.xa_sync = {st_ff.xa_sync[1:0], crystal_a_input};
    nxt_st.xb_sync = {st_ff.xb_sync[1:0], crystal_b_input};
    xa_lvl  = cimf_sync_level(st_ff.xa_sync, st_ff.xa_acc);
    xb_lvl  = cimf_sync_level(st_ff.xb_sync, st_ff.xb_acc);
    xa_rise = xa_lvl && !st_ff.xa_acc;
    xb_rise = xb_lvl && !st_ff.xb_acc;
    nxt_st.xa_acc = xa_lvl;
    nxt_st.xb_acc = xb_lvl;
    // whatever clock arrives is simply divided, no frequency is assumed
    rate_edge = st_ff.fmt[CIMF_BIT_XTAL] ? xb_rise : xa_rise; // [R11] [R13]
    // minus one: the counter runs 0 to factor-1, so a tick every factor edges
    div_lim   = CIMF_DIV_TABLE[st_ff.fmt[3:1]] - 12'd1;       // [R12]
    nxt_st.tick = 1'b0;
    // >= rather than ==: a smaller factor written mid-count wraps at once
    // instead of running on past 4095 and losing a whole counter lap
    if (rate_edge)
    begin
      if (st_ff.div_cnt >= div_lim)
      begin
        nxt_st.div_cnt = 12'h000;
        nxt_st.tick    = 1'b1;
      end
      else
        nxt_st.div_cnt = st_ff.div_cnt + 12'd1;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // reset values give muted aux and outputs, zero inputs and format
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // crystal stages clear too; a pin already high at release counts one edge
      st_ff        <= '0;
      st_ff.in_l   <= CIMF_RST_INPUT;                         // [R16]
      st_ff.in_r   <= CIMF_RST_INPUT;
      st_ff.aux1_l <= CIMF_RST_AUX;                           // [R6]
      st_ff.aux1_r <= CIMF_RST_AUX;
      st_ff.aux2_l <= CIMF_RST_AUX;
      st_ff.aux2_r <= CIMF_RST_AUX;
      st_ff.out_l  <= CIMF_RST_OUTPUT;                        // [R8]
      st_ff.out_r  <= CIMF_RST_OUTPUT;
      st_ff.fmt    <= CIMF_RST_FORMAT;                        // [R16]
    end
    else
      st_ff <= nxt_st;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // decoded views; all come straight from held register bits
  always_comb
  begin
    host_rdata           = st_ff.rdata;
    mode_change_unlock   = st_ff.unlock;
    indirect_index_field = st_ff.index;
    left_input           = cimf_dec_in(st_ff.in_l);
    right_input          = cimf_dec_in(st_ff.in_r);
    left_aux_one         = cimf_dec_aux(st_ff.aux1_l);
    right_aux_one        = cimf_dec_aux(st_ff.aux1_r);
    left_aux_two         = cimf_dec_aux(st_ff.aux2_l);
    right_aux_two        = cimf_dec_aux(st_ff.aux2_r);
    left_output          = cimf_dec_out(st_ff.out_l, st_ff.unlock);
    right_output         = cimf_dec_out(st_ff.out_r, st_ff.unlock);
    // format fields: rate clock, divider and sample layout for the data path
    rate_format.crystal_b     = st_ff.fmt[CIMF_BIT_XTAL];     // [R11]
    rate_format.divide_sel    = st_ff.fmt[3:1];
    rate_format.divide_factor = CIMF_DIV_TABLE[st_ff.fmt[3:1]];
    rate_format.stereo        = st_ff.fmt[CIMF_BIT_STEREO];   // [R14]
    rate_format.fmt = cimf_fmt_e'({st_ff.fmt[CIMF_BIT_COMPAND],
                                   st_ff.fmt[CIMF_BIT_FMT]}); // [R15]
    // codes 4 and 5 flagged on crystal a; the divider still runs
    rate_format.unsupported = !st_ff.fmt[CIMF_BIT_XTAL] &&
                              (st_ff.fmt[3:1] == 3'd4 || st_ff.fmt[3:1] == 3'd5); // [R12]
    // tick straight from its flop: one core cycle wide per divided edge
    sample_tick = st_ff.tick;
  end

endmodule : cimf_regs

/* testbench/cimf_regs_checker.sv */
// Purpose: port checks on the indexed register bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound into every instance of the register bank
`timescale 1ns/1ps
module cimf_regs_checker
  import cimf_pkg::*;
(
  // clock and reset
  input wire logic         core_clk,
  input wire logic         rst_n,
  // host byte port
  input wire logic [1:0]   direct_port_select,
  input wire logic         host_wr,
  input wire logic         host_rd,
  input wire logic [7:0]   host_wdata,
  input wire logic [7:0]   host_rdata,
  input wire logic         init_busy,
  // state and decoded controls
  input wire logic         mode_change_unlock,
  input wire logic [3:0]   indirect_index_field,
  input wire cimf_input_s  left_input,
  input wire cimf_aux_s    left_aux_one,
  input wire cimf_out_s    left_output,
  input wire cimf_out_s    right_output,
  input wire cimf_format_s rate_format
);
  // ****************
  // helpers
  // ****************
  // index byte kept one edge so the stored index can be compared later
  logic [3:0] last_ix;
  logic       dat_wr;

  always_ff @(posedge core_clk) last_ix <= host_wdata[3:0];
  assign dat_wr = host_wr && direct_port_select == CIMF_PORT_DATA;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_INDEX_TAKEN: assert property (
    host_wr && direct_port_select == CIMF_PORT_INDEX |=> indirect_index_field == last_ix)
    else $error("index write not stored");
  AST_UNLOCK_MUTES: assert property (
    mode_change_unlock |-> left_output.mute && right_output.mute)
    else $error("outputs not muted while unlocked");
  AST_IN_GAIN: assert property (int'(left_input.gain_db10) == 15 * int'(left_input.gain)
    + ((left_input.boost_on && left_input.src == CIMF_SRC_MIC) ? 200 : 0))
    else $error("input gain wrong");
  AST_AUX_GAIN: assert property (
    int'(left_aux_one.gain_db10) == 15 * (8 - int'(left_aux_one.atten)))
    else $error("aux gain wrong");
  AST_OUT_GAIN: assert property (
    int'(left_output.gain_db10) == -15 * int'(left_output.atten))
    else $error("output attenuation wrong");
  AST_DIVIDE: assert property (
    rate_format.divide_factor == CIMF_DIV_TABLE[rate_format.divide_sel]
    && rate_format.unsupported == (!rate_format.crystal_b
    && rate_format.divide_sel inside {3'h4, 3'h5}))
    else $error("divide factor wrong");
  AST_FMT_LOCKED: assert property (dat_wr && !mode_change_unlock
    && indirect_index_field == CIMF_IX_FORMAT |=> $stable(rate_format))
    else $error("locked format changed");
  AST_BUSY_READ: assert property (
    host_rd && init_busy |=> host_rdata == CIMF_INIT_READ)
    else $error("busy read not 80h");

  cover property (dat_wr && mode_change_unlock);
  cover property (host_rd && init_busy);
  cover property (dat_wr && indirect_index_field == CIMF_IX_FORMAT);
endmodule : cimf_regs_checker

bind cimf_regs cimf_regs_checker chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .direct_port_select(direct_port_select), .host_wr(host_wr), .host_rd(host_rd),
  .host_wdata(host_wdata), .host_rdata(host_rdata), .init_busy(init_busy),
  .mode_change_unlock(mode_change_unlock), .indirect_index_field(indirect_index_field),
  .left_input(left_input), .left_aux_one(left_aux_one), .left_output(left_output),
  .right_output(right_output), .rate_format(rate_format));

/* testbench/cimf_host_model.sv */
// Purpose: host processor model on the byte port
// Assumes: strobes launched at the falling edge, one cycle long
// Notes:   released write data shows the inverse of the last byte
`timescale 1ns/1ps
module cimf_host_model
  import cimf_pkg::*;
(
  // clock
  input  wire logic       core_clk,
  // host byte port
  output logic [1:0]      direct_port_select,
  output logic            host_wr,
  output logic            host_rd,
  output logic [7:0]      host_wdata,
  input  wire logic [7:0] host_rdata
);
  // ****************
  // bus cycles
  // ****************
  initial
  begin
    direct_port_select = 2'h0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end

  // index writes precede data access; caller keeps reserved bits zero
  task automatic put(input logic [1:0] sel, input logic [7:0] d);
    @(negedge core_clk);
    direct_port_select = sel;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge core_clk);
    host_wr = 1'b0;
    host_wdata = ~d; // a stale byte must not pass for a live one
  endtask : put

  // answer is registered, so it is taken a full cycle after the strobe
  task automatic get(input logic [1:0] sel, output logic [7:0] d);
    @(negedge core_clk);
    direct_port_select = sel;
    host_rd = 1'b1;
    @(negedge core_clk);
    host_rd = 1'b0;
    @(negedge core_clk);
    d = host_rdata;
  endtask : get
endmodule : cimf_host_model

/* testbench/cimf_regs_test.sv */
// Purpose: self-checking bench for the indexed register bank
// Assumes: host and control inputs change at the falling edge of core_clk; crystal inputs run free
// Notes:   a byte model of the registers predicts every read
`timescale 1ns/1ps
module cimf_regs_test
  import cimf_pkg::*;
;
  logic         core_clk, rst_n, init_busy, xa, xb, wr_s, rd_s, unl, tick;
  logic [1:0]   sel;
  logic [7:0]   wdat, rdat, d;
  logic [3:0]   ix;
  cimf_input_s  lin;
  cimf_aux_s    lax;
  cimf_out_s    lout, rout;
  cimf_format_s fmt;
  logic [7:0]   mdl [9] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00};
  logic [3:0]   m_ix = 4'h0;
  logic         m_unl = 1'b0;
  int           error_cnt = 0, comparisons = 0, cycles = 0, seed = 32'h94f5, i;

  cimf_regs dut_u (.core_clk(core_clk), .rst_n(rst_n), .direct_port_select(sel),
    .host_wr(wr_s), .host_rd(rd_s), .host_wdata(wdat), .host_rdata(rdat),
    .init_busy(init_busy), .mode_change_unlock(unl), .indirect_index_field(ix),
    .left_input(lin), .right_input(), .left_aux_one(lax), .right_aux_one(),
    .left_aux_two(), .right_aux_two(), .left_output(lout), .right_output(rout),
    .rate_format(fmt), .crystal_a_input(xa), .crystal_b_input(xb), .sample_tick(tick));
  cimf_host_model host_u (.core_clk(core_clk), .direct_port_select(sel), .host_wr(wr_s),
    .host_rd(rd_s), .host_wdata(wdat), .host_rdata(rdat));

  // ****************
  // clocks, watchdog
  // ****************
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // crystals far from nominal: any clock is divided alike
  initial
  begin
    xa = 1'b0;
    #7;
    forever #50 xa = ~xa;
  end
  initial
  begin
    xb = 1'b0;
    #11;
    forever #62.5 xb = ~xb;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      error_cnt++;
      conclude();
    end
  end

  // ****************
  // tasks
  // ****************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chkt(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chkt
  // bits each register holds; the rest are reserved and kept zero by the host
  function automatic logic [7:0] held(input logic [3:0] x);
    return x < 2 ? CIMF_MASK_INPUT : x < 6 ? CIMF_MASK_AUX :
           x < 8 ? CIMF_MASK_OUTPUT : CIMF_MASK_FORMAT;
  endfunction : held
  // writes update the model as the registers should
  task automatic wr(input logic [1:0] s, input logic [7:0] v);
    host_u.put(s, v);
    if (s == CIMF_PORT_INDEX)
    begin
      m_ix = v[3:0];
      m_unl = v[6];
    end
    else if (s == CIMF_PORT_DATA && !init_busy && m_ix < 9 && (m_ix != 8 || m_unl))
      mdl[m_ix] = v & held(m_ix);
  endtask : wr
  task automatic rd(input logic [1:0] s, input string what);
    logic [7:0] got;
    host_u.get(s, got);
    chk(what, init_busy ? CIMF_INIT_READ : s == CIMF_PORT_INDEX ?
        {1'b0, m_unl, 2'b00, m_ix} : mdl[m_ix], got);
  endtask : rd
  // long bound: the old divide count may still be running out
  task automatic wait_tick;
    for (int n = 0; n < 25000 && tick !== 1'b1; n++) @(negedge core_clk);
    @(negedge core_clk);
  endtask : wait_tick
  task automatic gap(input int want, input string what);
    realtime t0;
    wait_tick();
    wait_tick();
    t0 = $realtime;
    wait_tick();
    chkt(what, want, int'($realtime - t0));
  endtask : gap
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // ****************
  // sequence
  // ****************
  initial
  begin
    rst_n = 1'b0;
    init_busy = 1'b0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    for (i = 0; i < 9; i++)
    begin
      wr(2'h0, 8'(i));
      rd(2'h1, "reset value");
    end
    chk("output mute", 8'h01, 8'(lout.mute));
    $display("done reset");
    for (i = 0; i < 24; i++)
    begin
      d = 8'($unsigned($random(seed)) % 8);
      wr(2'h0, d);
      wr(2'h1, 8'($random(seed)) & held(d[3:0]));
      rd(2'h1, "random readback");
    end
    chk("aux mute", 8'(mdl[2][7]), 8'(lax.mute));
    wr(2'h0, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(2'h1, {2'(i), 6'h2F});
      chk("input source", 8'(i), 8'(lin.src));
      chkt("input gain", 15 * 15 + (i == 2 ? 200 : 0), int'(lin.gain_db10));
    end
    $display("done mixer");
    wr(2'h0, 8'h08);
    wr(2'h1, 8'h5F);
    rd(2'h1, "locked format");
    wr(2'h0, 8'h48);
    chk("unlock mute", 8'h03, {6'h00, lout.mute, rout.mute});
    chk("unlock and index", 8'h18, {3'h0, unl, ix});
    rd(2'h0, "index port");
    for (i = 0; i < 4; i++)
    begin
      wr(2'h1, {1'b0, i[0], i[1], i[0], 4'h0});
      rd(2'h1, "format");
      chk("sample format", 8'(i), 8'(fmt.fmt));
      chk("stereo", 8'(i[0]), 8'(fmt.stereo));
    end
    wr(2'h1, 8'h0A);
    chk("unsupported", 8'h01, 8'(fmt.unsupported));
    chkt("divide factor", 384, int'(fmt.divide_factor));
    wr(2'h1, 8'h0B);
    gap(384 * 125, "crystal b gap");
    wr(2'h1, 8'h0C);
    gap(512 * 100, "crystal a gap");
    wr(2'h0, 8'h08);
    chk("mute restored", 8'(mdl[6][7]), 8'(lout.mute));
    $display("done format");
    wr(2'h0, 8'h02);
    init_busy = 1'b1;
    wr(2'h1, 8'h15);
    rd(2'h1, "busy data");
    rd(2'h0, "busy index");
    init_busy = 1'b0;
    rd(2'h1, "after busy");
    $display("done busy");
    conclude();
  end
endmodule : cimf_regs_test
